/* hdl/eivu_consts.vh */
// Register map, field positions, encodings and vectors of the irq unit
`ifndef EIVU_CONSTS_VH
`define EIVU_CONSTS_VH

// ==========================================================
// Register indices; byte address is four times the index
`define EIVU_IDX_PCMSK0   6'h0f
`define EIVU_IDX_PCMSK1   6'h10
`define EIVU_IDX_PCFLAG   6'h11
`define EIVU_IDX_PCCTL    6'h12
`define EIVU_IDX_MASK     6'h13
`define EIVU_IDX_FLAG     6'h14
`define EIVU_IDX_SENSE    6'h15
`define EIVU_IDX_STATUS   6'h16
`define EIVU_ADDR_PCMSK0  {`EIVU_IDX_PCMSK0, 2'b00}
`define EIVU_ADDR_PCMSK1  {`EIVU_IDX_PCMSK1, 2'b00}
`define EIVU_ADDR_PCFLAG  {`EIVU_IDX_PCFLAG, 2'b00}
`define EIVU_ADDR_PCCTL   {`EIVU_IDX_PCCTL, 2'b00}
`define EIVU_ADDR_MASK    {`EIVU_IDX_MASK, 2'b00}
`define EIVU_ADDR_FLAG    {`EIVU_IDX_FLAG, 2'b00}
`define EIVU_ADDR_SENSE   {`EIVU_IDX_SENSE, 2'b00}
`define EIVU_ADDR_STATUS  {`EIVU_IDX_STATUS, 2'b00}

// ==========================================================
// Reset values
`define EIVU_RST_REG8     8'h00
`define EIVU_RST_MSK1     4'h0
`define EIVU_RST_SENSE    2'h0

// ==========================================================
// Field positions
`define EIVU_BIT_EXT0_EN  0
`define EIVU_BIT_EXT0_FLG 0
`define EIVU_BIT_PC0      0
`define EIVU_BIT_PC1      1
`define EIVU_SENSE_MSB    1
`define EIVU_SENSE_LSB    0

// ==========================================================
// Sense select encodings
`define EIVU_SENSE_LOW    2'h0
`define EIVU_SENSE_ANY    2'h1
`define EIVU_SENSE_FALL   2'h2
`define EIVU_SENSE_RISE   2'h3

// ==========================================================
// Vector word addresses
`define EIVU_VEC_RESET    4'h0
`define EIVU_VEC_EXT0     4'h1
`define EIVU_VEC_PC0      4'h2
`define EIVU_VEC_PC1      4'h3
`define EIVU_VEC_TCAPT    4'h4
`define EIVU_VEC_TOVF     4'h5
`define EIVU_VEC_TCMPA    4'h6
`define EIVU_VEC_TCMPB    4'h7
`define EIVU_VEC_ACMP     4'h8
`define EIVU_VEC_WDOG     4'h9
`define EIVU_VEC_SUPPLY   4'ha
`define EIVU_VEC_CONV     4'hb
`define EIVU_VEC_SRXS     4'hc
`define EIVU_VEC_SRXC     4'hd
`define EIVU_VEC_SDRE     4'he
`define EIVU_VEC_STXC     4'hf

// ==========================================================
// Settling cycles of the pin synchronisers after reset
`define EIVU_SETTLE       3'h5

`endif

/* hdl/eivu_top.v */
// External interrupt, pin change and vector selection unit
//
// Operation
// - External request vector at 0x001, pin change groups at 0x002, 0x003.
// - 0x004..0x00F: timer, comparator, watchdog, monitor, converter, serial.
// - After any reset the presented vector is 0x000.
// - Requests arise from pin levels even when pins act as outputs.
// - An enabled pin toggle raises its group request; masked pins ignored.
// - Pin change detection needs no I/O clock; it can wake deep sleep.
// - Low-level mode keeps requesting while the pin stays low.
// - Edge sensing uses the running I/O clock; stopped clock gives none.
// - Low level detected without I/O clock, waking from every sleep mode.
// - Level gone before start-up: wake, but no interrupt taken.
// - Sense 00 low, 01 any change, 10 falling, 11 rising.
// - Input sampled before edge detection; pulses over two clocks count.
// - External vector taken only with mask bit 0 and global enable.
// - Sense field bits 1:0 at offset 0x15, reset 0x00.
// - External flag sets on trigger, clears on vector or write one.
// - Each pin group flag sets on change, clears on vector or write one.
// - Group interrupt taken only with group enable and global enable.
`timescale 1ns/1ps
`default_nettype none
`include "eivu_consts.vh"

module eivu_top (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        ext_request0,
  input  wire [11:0] pin_change_inputs,
  input  wire        io_clk_en,
  input  wire        global_irq_en,
  input  wire [11:0] periph_irq_req,
  input  wire        vector_ack,
  output reg         irq_req,
  output reg  [3:0]  irq_vector,
  output reg         wake_req
);

  // ========================================================
  // Helper functions
  function [3:0] lowest_vec;
    input [15:0] req;
    integer i;
    begin
      lowest_vec = `EIVU_VEC_RESET;
      for (i = 15; i > 0; i = i - 1) begin
        if (req[i]) begin
          lowest_vec = i[3:0];
        end
      end
    end
  endfunction

  // One-hot register select; shared by write, clear and read decode
  localparam SEL_PCMSK0 = 0;
  localparam SEL_PCMSK1 = 1;
  localparam SEL_PCFLAG = 2;
  localparam SEL_PCCTL  = 3;
  localparam SEL_MASK   = 4;
  localparam SEL_FLAG   = 5;
  localparam SEL_SENSE  = 6;
  localparam SEL_STATUS = 7;

  function [7:0] reg_sel;
    input [7:0] a;
    begin
      reg_sel = 8'h00;
      if (a == `EIVU_ADDR_PCMSK0) begin
        reg_sel[SEL_PCMSK0] = 1'b1;
      end else if (a == `EIVU_ADDR_PCMSK1) begin
        reg_sel[SEL_PCMSK1] = 1'b1;
      end else if (a == `EIVU_ADDR_PCFLAG) begin
        reg_sel[SEL_PCFLAG] = 1'b1;
      end else if (a == `EIVU_ADDR_PCCTL) begin
        reg_sel[SEL_PCCTL] = 1'b1;
      end else if (a == `EIVU_ADDR_MASK) begin
        reg_sel[SEL_MASK] = 1'b1;
      end else if (a == `EIVU_ADDR_FLAG) begin
        reg_sel[SEL_FLAG] = 1'b1;
      end else if (a == `EIVU_ADDR_SENSE) begin
        reg_sel[SEL_SENSE] = 1'b1;
      end else if (a == `EIVU_ADDR_STATUS) begin
        reg_sel[SEL_STATUS] = 1'b1;
      end
    end
  endfunction

  // ========================================================
  // Pin synchronisers, three stages with agreement filter
  wire [12:0] raw_pins = {ext_request0, pin_change_inputs};
  reg  [12:0] sync1_q;
  reg  [12:0] sync2_q;
  reg  [12:0] sync3_q;
  reg  [12:0] filt_q;
  reg  [12:0] prev_q;
  reg  [2:0]  settle_q;

  genvar g;
  generate
    for (g = 0; g < 13; g = g + 1) begin : g_sync
      always @(posedge ref_clk) begin
        if (!rst_n) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
          sync3_q[g] <= 1'b0;
          filt_q[g]  <= 1'b0;
        end else begin
          sync1_q[g] <= raw_pins[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
          if (sync2_q[g] == sync3_q[g]) begin
            filt_q[g] <= sync3_q[g];
          end
        end
      end
    end
  endgenerate

  // Pins idle high would look like edges after reset; wait until
  // prev_q has caught up with the filtered pins
  wire armed = (settle_q == `EIVU_SETTLE);

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      prev_q   <= 13'h0000;
      settle_q <= 3'h0;
    end else begin
      prev_q <= filt_q;
      if (!armed) begin
        settle_q <= settle_q + 3'h1;
      end
    end
  end

  wire [12:0] chg = (filt_q ^ prev_q) & {13{armed}};

  // ========================================================
  // Registers
  reg  [7:0] pcmsk0_q;
  reg  [3:0] pcmsk1_q;
  reg  [1:0] pcctl_q;
  reg  [1:0] pcflag_q;
  reg        mask_q;
  reg        extflag_q;
  reg  [1:0] sense_q;

  wire acc = psel & penable & pready;
  wire wr  = acc & pwrite;
  wire [7:0] wb = pwdata[7:0];
  wire [7:0] sel = reg_sel(paddr);

  wire lvl_mode = (sense_q == `EIVU_SENSE_LOW);
  wire ext_low  = armed & ~filt_q[12];
  wire ext_rise = chg[12] & filt_q[12];
  wire ext_fall = chg[12] & ~filt_q[12];

  // ========================================================
  // External request trigger
  reg ext_trig;
  always @* begin
    ext_trig = 1'b0;
    if (io_clk_en) begin
      case (sense_q)
        `EIVU_SENSE_ANY:  ext_trig = chg[12];
        `EIVU_SENSE_FALL: ext_trig = ext_fall;
        `EIVU_SENSE_RISE: ext_trig = ext_rise;
        default:          ext_trig = 1'b0;
      endcase
    end
  end

  // Pin change detection runs regardless of the I/O clock
  wire pc0_hit = |(chg[7:0] & pcmsk0_q);
  wire pc1_hit = |(chg[11:8] & pcmsk1_q);

  wire ack_ext = vector_ack & (irq_vector == `EIVU_VEC_EXT0);
  wire ack_pc0 = vector_ack & (irq_vector == `EIVU_VEC_PC0);
  wire ack_pc1 = vector_ack & (irq_vector == `EIVU_VEC_PC1);

  wire clr_ext = ack_ext |
                 (wr & sel[SEL_FLAG] & wb[`EIVU_BIT_EXT0_FLG]);
  wire clr_pc0 = ack_pc0 |
                 (wr & sel[SEL_PCFLAG] & wb[`EIVU_BIT_PC0]);
  wire clr_pc1 = ack_pc1 |
                 (wr & sel[SEL_PCFLAG] & wb[`EIVU_BIT_PC1]);

  // Set wins over clear so no event is lost
  wire extflag_d = lvl_mode ? 1'b0 :
                   (ext_trig | (extflag_q & ~clr_ext));
  wire [1:0] pcflag_d;
  assign pcflag_d[0] = pc0_hit | (pcflag_q[0] & ~clr_pc0);
  assign pcflag_d[1] = pc1_hit | (pcflag_q[1] & ~clr_pc1);

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pcmsk0_q  <= `EIVU_RST_REG8;
      pcmsk1_q  <= `EIVU_RST_MSK1;
      pcctl_q   <= 2'h0;
      pcflag_q  <= 2'h0;
      mask_q    <= 1'b0;
      extflag_q <= 1'b0;
      sense_q   <= `EIVU_RST_SENSE;
    end else begin
      extflag_q <= extflag_d;
      pcflag_q  <= pcflag_d;
      if (wr) begin
        if (sel[SEL_PCMSK0]) begin
          pcmsk0_q <= wb;
        end else if (sel[SEL_PCMSK1]) begin
          pcmsk1_q <= wb[3:0];
        end else if (sel[SEL_PCCTL]) begin
          pcctl_q <= wb[1:0];
        end else if (sel[SEL_MASK]) begin
          mask_q <= wb[`EIVU_BIT_EXT0_EN];
        end else if (sel[SEL_SENSE]) begin
          sense_q <= wb[`EIVU_SENSE_MSB:`EIVU_SENSE_LSB];
        end
      end
    end
  end

  // ========================================================
  // Request collection and vector choice
  // Level request follows the live pin: if it is gone by the time
  // the core looks, no vector is taken and code resumes after sleep.
  wire ext_pend = lvl_mode ? ext_low : extflag_q;
  wire [15:0] req;
  assign req[0]    = 1'b0;
  assign req[1]    = global_irq_en & mask_q & ext_pend;
  assign req[2]    = global_irq_en & pcctl_q[`EIVU_BIT_PC0] &
                     pcflag_q[0];
  assign req[3]    = global_irq_en & pcctl_q[`EIVU_BIT_PC1] &
                     pcflag_q[1];
  assign req[15:4] = {12{global_irq_en}} & periph_irq_req;

  // Wake ignores the global enable: sleep exit needs only the source
  wire wake_d = (mask_q & lvl_mode & ext_low) |
                (mask_q & extflag_q) |
                (pcctl_q[`EIVU_BIT_PC0] & pcflag_q[0]) |
                (pcctl_q[`EIVU_BIT_PC1] & pcflag_q[1]);

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_req    <= 1'b0;
      irq_vector <= `EIVU_VEC_RESET;
      wake_req   <= 1'b0;
    end else begin
      wake_req <= wake_d;
      if (vector_ack) begin
        // Drop for a cycle so a stale request is not taken twice
        irq_req <= 1'b0;
      end else begin
        irq_req    <= |req;
        irq_vector <= lowest_vec(req);
      end
    end
  end

  // ========================================================
  // APB slave, one wait state, registered answer
  reg [7:0] rd8;
  reg       hit;
  always @* begin
    rd8 = 8'h00;
    hit = 1'b1;
    if (sel[SEL_PCMSK0]) begin
      rd8 = pcmsk0_q;
    end else if (sel[SEL_PCMSK1]) begin
      rd8 = {4'h0, pcmsk1_q};
    end else if (sel[SEL_PCFLAG]) begin
      rd8 = {6'h00, pcflag_q};
    end else if (sel[SEL_PCCTL]) begin
      rd8 = {6'h00, pcctl_q};
    end else if (sel[SEL_MASK]) begin
      rd8 = {7'h00, mask_q};
    end else if (sel[SEL_FLAG]) begin
      rd8 = {7'h00, extflag_q};
    end else if (sel[SEL_SENSE]) begin
      rd8 = {6'h00, sense_q};
    end else if (sel[SEL_STATUS]) begin
      rd8 = {filt_q[12], wake_req, 1'b0, irq_req, irq_vector};
    end else begin
      hit = 1'b0;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel & penable & ~pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h00000000 : {24'h000000, rd8};
      pslverr <= ~hit;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* bench/eivu_asserts.sv */
// Port checker of the interrupt and vector unit
`timescale 1ns/1ps
`default_nettype none
module eivu_asserts (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        global_irq_en,
  input wire logic [11:0] periph_irq_req,
  input wire logic        vector_ack,
  input wire logic        irq_req,
  input wire logic [3:0]  irq_vector,
  input wire logic        wake_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Bus timing
  property p_one_wait;
    $rose(penable) && psel |-> !pready ##1 pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait state wrong");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("stray pslverr");
  property p_upper_zero;
    pready |-> prdata[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
  // ==========================================================
  // Vector selection
  property p_reset_vec;
    $rose(rst_n) |-> irq_vector == 4'h0 && !irq_req;
  endproperty
  a_reset_vec: assert property (p_reset_vec)
    else $error("reset vector");
  property p_gie_off;
    !global_irq_en |=> !irq_req;
  endproperty
  a_gie_off: assert property (p_gie_off)
    else $error("req w/o enable");
  property p_ack_drop;
    vector_ack |=> !irq_req;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("req after ack");
  property p_prio;
    global_irq_en && periph_irq_req[0] && !vector_ack
      |=> irq_req && irq_vector <= 4'h4;
  endproperty
  a_prio: assert property (p_prio)
    else $error("priority wrong");
  c_err: cover property (pslverr);
  c_ack: cover property (vector_ack);
  c_wake: cover property ($rose(wake_req));
endmodule
bind eivu_top eivu_asserts i_chk (.ref_clk, .rst_n, .psel, .penable,
  .prdata, .pready, .pslverr, .global_irq_en, .periph_irq_req,
  .vector_ack, .irq_req, .irq_vector, .wake_req);
`default_nettype wire

/* bench/eivu_core_model.sv */
// Core-side model that takes one vector per request
`timescale 1ns/1ps
`default_nettype none
module eivu_core_model (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       take,
  input wire logic       irq_req,
  input wire logic [3:0] irq_vector,
  output var logic       vector_ack,
  output var logic [3:0] taken_vec
);
  // ==========================================================
  // Ack only a standing request, never twice running
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      vector_ack <= 1'b0;
      taken_vec <= 4'h0;
    end else begin
      vector_ack <= take && irq_req && !vector_ack;
      if (take && irq_req && !vector_ack)
        taken_vec <= irq_vector;
    end
  end
endmodule
`default_nettype wire

/* bench/external_irq_and_vector_unit_test.sv */
// Self-checking bench of the interrupt and vector unit
`timescale 1ns/1ps
`default_nettype none
`include "eivu_consts.vh"
module external_irq_and_vector_unit_test;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, er, take;
  logic ext_request0, io_clk_en, global_irq_en, vector_ack, irq_req;
  logic wake_req;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] pin_change_inputs, periph_irq_req;
  logic [3:0] irq_vector, taken_vec;
  int fails, cmp_count, i;
  eivu_top i_dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ext_request0, .pin_change_inputs,
    .io_clk_en, .global_irq_en, .periph_irq_req, .vector_ack, .irq_req,
    .irq_vector, .wake_req);
  eivu_core_model i_core (.ref_clk, .rst_n, .take, .irq_req, .irq_vector,
    .vector_ack, .taken_vec);
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(rd, e);
  endtask
  task conclude;
    $display("fails=%0d compares=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================================
  // Clock, watchdog, tests
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    #400000;
    fails++;
    conclude;
  end
  initial begin
    {rst_n, psel, penable, pwrite, take, global_irq_en} = 6'h0;
    {paddr, pwdata, pin_change_inputs, periph_irq_req} = 64'h0;
    {ext_request0, io_clk_en} = 2'h3;
    fails = 0;
    cmp_count = 0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk(irq_vector, 32'h0);
    repeat (4) @(posedge ref_clk);
    for (i = 15; i < 22; i++) rdc(8'(i * 4), 32'h0);
    apb(8'h00, 1'b0, 32'h0);
    chk(er, 1);
    // Pin groups with the I/O clock stopped
    global_irq_en <= 1'b1;
    io_clk_en <= 1'b0;
    apb(`EIVU_ADDR_PCMSK0, 1'b1, 32'h01);
    apb(`EIVU_ADDR_PCMSK1, 1'b1, 32'h08);
    apb(`EIVU_ADDR_PCCTL, 1'b1, 32'h03);
    pin_change_inputs <= 12'h002;
    repeat (10) @(posedge ref_clk);
    rdc(`EIVU_ADDR_PCFLAG, 32'h0);
    pin_change_inputs <= 12'h803;
    repeat (10) @(posedge ref_clk);
    rdc(`EIVU_ADDR_PCFLAG, 32'h3);
    chk(irq_vector, 32'h2);
    take <= 1'b1;
    @(posedge ref_clk);
    take <= 1'b0;
    repeat (5) @(posedge ref_clk);
    chk(taken_vec, 32'h2);
    chk(irq_vector, 32'h3);
    apb(`EIVU_ADDR_PCCTL, 1'b1, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk(irq_req, 1'b0);
    apb(`EIVU_ADDR_PCFLAG, 1'b1, 32'h3);
    rdc(`EIVU_ADDR_PCFLAG, 32'h0);
    // Edge and change sensing
    io_clk_en <= 1'b1;
    apb(`EIVU_ADDR_MASK, 1'b1, 32'h1);
    for (i = 1; i < 4; i++) begin
      apb(`EIVU_ADDR_SENSE, 1'b1, i);
      ext_request0 <= 1'b0;
      repeat (10) @(posedge ref_clk);
      rdc(`EIVU_ADDR_FLAG, i != 3);
      apb(`EIVU_ADDR_FLAG, 1'b1, 32'h1);
      ext_request0 <= 1'b1;
      repeat (10) @(posedge ref_clk);
      rdc(`EIVU_ADDR_FLAG, i != 2);
      apb(`EIVU_ADDR_FLAG, 1'b1, 32'h1);
    end
    // Rising edge flag taken through its vector clears itself
    ext_request0 <= 1'b0;
    repeat (4) @(posedge ref_clk);
    ext_request0 <= 1'b1;
    repeat (10) @(posedge ref_clk);
    take <= 1'b1;
    @(posedge ref_clk);
    take <= 1'b0;
    repeat (5) @(posedge ref_clk);
    chk(taken_vec, 32'h1);
    rdc(`EIVU_ADDR_FLAG, 32'h0);
    apb(`EIVU_ADDR_SENSE, 1'b1, 32'h2);
    io_clk_en <= 1'b0;
    ext_request0 <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rdc(`EIVU_ADDR_FLAG, 32'h0);
    // Low level held, so it is seen asleep too
    ext_request0 <= 1'b1;
    repeat (10) @(posedge ref_clk);
    apb(`EIVU_ADDR_SENSE, 1'b1, 32'h0);
    ext_request0 <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk(wake_req, 1'b1);
    chk({irq_req, irq_vector}, 32'h11);
    rdc(`EIVU_ADDR_FLAG, 32'h0);
    global_irq_en <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({irq_req, wake_req}, 32'h1);
    ext_request0 <= 1'b1;
    global_irq_en <= 1'b1;
    apb(`EIVU_ADDR_MASK, 1'b1, 32'h0);
    repeat (10) @(posedge ref_clk);
    // Peripheral vectors, one at a time
    for (i = 0; i < 12; i++) begin
      periph_irq_req <= 12'h001 << i;
      repeat (3) @(posedge ref_clk);
      chk(irq_vector, i + 4);
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk(irq_vector, 32'h0);
    rdc(`EIVU_ADDR_SENSE, 32'h0);
    conclude;
  end
endmodule
`default_nettype wire
